// File: oogs_pkg.sv
package oogs_pkg;

  // ********************
  // Register map (byte addresses, one aligned word each)
  // ********************
  localparam logic [7:0] OFS_WIDTH_PRE = 8'h00;
  localparam logic [7:0] OFS_WIDTH_POST = 8'h04;
  localparam logic [7:0] OFS_ON_DELAY = 8'h08;
  localparam logic [7:0] OFS_OFF_DELAY = 8'h0c;
  localparam logic [7:0] OFS_STOP_POS_INT = 8'h10;
  localparam logic [7:0] OFS_SWITCH_TIME = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_MON_STOP_POS = 8'h1c;
  localparam logic [7:0] OFS_MON_POSITION = 8'h20;
  localparam logic [7:0] OFS_MON_DEVIATION = 8'h24;

  // ********************
  // Field widths and limits
  // ********************
  localparam int WIDTH_W = 9;
  localparam int DELAY_W = 10;
  localparam int POS_W = 15;
  localparam int SWT_W = 16;
  localparam logic [DELAY_W-1:0] DELAY_MAX = 10'h3e8;
  localparam logic [POS_W-1:0] DEV_LIMIT = 15'h01f4;

  // STATUS bit positions
  localparam int ST_COMPLETE = 0;
  localparam int ST_ORIENTING = 1;
  localparam int ST_POST_WIDTH = 2;
  localparam int ST_RAW_COMPLETE = 3;
  localparam int ST_GEAR_LSB = 4;
  localparam int ST_BANK_B = 6;
  localparam int ST_SWITCHING = 7;
  localparam int ST_FORCED = 8;

  // ********************
  // Reset values
  // ********************
  localparam logic [WIDTH_W-1:0] RST_WIDTH_PRE = 9'h00a;
  localparam logic [WIDTH_W-1:0] RST_WIDTH_POST = 9'h005;
  localparam logic [DELAY_W-1:0] RST_ON_DELAY = 10'h000;
  localparam logic [DELAY_W-1:0] RST_OFF_DELAY = 10'h000;
  localparam logic [POS_W-1:0] RST_STOP_POS_INT = 15'h0000;
  localparam logic [SWT_W-1:0] RST_SWITCH_TIME = 16'h0000;

  // ********************
  // Timing
  // ********************
  localparam int CLK_HZ = 125000000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: oogs_delay_timer.sv
`timescale 1ns/1ps
module oogs_delay_timer #(
  parameter int CW = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic tick,
  input wire logic raw_in,
  input wire logic [CW-1:0] on_delay,
  input wire logic [CW-1:0] off_delay,
  output logic delayed_out
);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] limit;

  assign limit = raw_in ? on_delay : off_delay;

  // Pending change follows raw input only after the delay; a bounce restarts it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      delayed_out <= 1'b0;
    end
    else if (ce)
    begin
      if (raw_in == delayed_out)
      begin
        cnt_reg <= '0;
      end
      else if (cnt_reg >= limit)
      begin
        delayed_out <= raw_in; // R6 R7
        cnt_reg <= '0;
      end
      else if (tick)
      begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

endmodule

// File: oogs_orient_out.sv
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
// Behaviour
// R1: Completion output on while request active and position inside current width.
// R2: Orienting output on while request active and deviation beyond current width.
// R3: Both outputs forced on when run off, coast-stop on, or alarm present.
// R4: Pre-stop completion width programmable from 0 to 511 pulses.
// R5: After stopping inside the width, a second 0 to 511 width applies.
// R6: Completion output asserts after a 0 to 1000 tick on-delay.
// R7: Completion output deasserts after a 0 to 1000 tick off-delay.
// R8: Delay timers touch only reported outputs, never the position decision.
// R9: Monitor shows internal plus external stop position, 0 to 32767.
// R10: Monitor shows shaft position forward from index datum, 0 to 32767.
// R11: Monitor shows signed deviation within +/-500, zero beyond that.
// R12: Positive deviation is forward offset, negative is reverse offset.
// R13: Gear code selects one of four parameter sets as a single group.
// R14: Code 00 gives set 1 bank A; other codes sets 2-4 bank B.
// R15: Optional transition time flagged when speed regulator bank changes.
// R16: Sequencer holds request active for orientation, inactive for speed mode.
// R17: Absolute deviation compared with active width; timers run on 10 ms tick.
// R18: Pre-stop width restored whenever the orientation request is removed.
module oogs_orient_out #(
  parameter int ADDR_W = 8,
  parameter int TICK_CYCLES = oogs_pkg::TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic orientation_request,
  input wire logic run_cmd,
  input wire logic coast_stop_cmd,
  input wire logic alarm_active,
  input wire logic shaft_at_rest,
  input wire logic [14:0] shaft_position,
  input wire logic [14:0] stop_pos_ext,
  input wire logic gear_select_lo,
  input wire logic gear_select_hi,
  output logic orient_complete_out,
  output logic orienting_out,
  output logic [1:0] gear_set,
  output logic speed_reg_bank_b,
  output logic reg_switch_active,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  initial
  begin
    if (ADDR_W < 8 || ADDR_W > 32)
      $error("ADDR_W must lie between 8 and 32");
    if (TICK_CYCLES < 2)
      $error("TICK_CYCLES must be at least 2");
  end

  // ********************
  // Reset release
  // ********************
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ********************
  // Settings
  // ********************
  logic [oogs_pkg::WIDTH_W-1:0] width_pre_reg;
  logic [oogs_pkg::WIDTH_W-1:0] width_post_reg;
  logic [oogs_pkg::DELAY_W-1:0] on_delay_reg;
  logic [oogs_pkg::DELAY_W-1:0] off_delay_reg;
  logic [oogs_pkg::POS_W-1:0] stop_pos_int_reg;
  logic [oogs_pkg::SWT_W-1:0] switch_time_reg;

  // ********************
  // 10 ms tick
  // ********************
  localparam int TCW = $clog2(TICK_CYCLES);
  localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYCLES - 1);
  logic [TCW-1:0] tick_cnt_reg;
  logic tick_reg;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      tick_reg <= (tick_cnt_reg == TICK_LAST); // R17
      tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? '0 : tick_cnt_reg + 1'b1;
    end
  end

  // ********************
  // Position arithmetic
  // ********************
  logic [oogs_pkg::POS_W-1:0] stop_cmd;
  logic [oogs_pkg::POS_W-1:0] dev;
  logic [oogs_pkg::POS_W-1:0] dev_abs;
  logic [oogs_pkg::POS_W-1:0] width_act;
  logic post_width_reg;
  logic in_window;
  logic complete_raw;
  logic orienting_raw;
  logic force_on;

  // Modular sum: stop position wraps within one revolution
  assign stop_cmd = oogs_pkg::POS_W'(stop_pos_int_reg + stop_pos_ext); // R9
  // Shortest signed path; positive means ahead in the forward direction
  assign dev = oogs_pkg::POS_W'(shaft_position - stop_cmd); // R12
  assign dev_abs = dev[oogs_pkg::POS_W-1] ? oogs_pkg::POS_W'(-dev) : dev; // R17
  assign width_act = post_width_reg ? {6'h00, width_post_reg} :
                                      {6'h00, width_pre_reg}; // R4 R5
  assign in_window = (dev_abs <= width_act); // R17
  assign complete_raw = orientation_request && in_window; // R1
  assign orienting_raw = orientation_request && !in_window; // R2
  assign force_on = !run_cmd || coast_stop_cmd || alarm_active; // R3

  // Width narrowing uses the undelayed decision so the timers cannot shift it
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      post_width_reg <= 1'b0;
    else if (clk_en)
    begin
      if (!orientation_request)
        post_width_reg <= 1'b0; // R18
      else if (complete_raw && shaft_at_rest)
        post_width_reg <= 1'b1; // R5 R8
    end
  end

  // ********************
  // Reported outputs
  // ********************
  logic complete_delayed;

  oogs_delay_timer #(
    .CW(oogs_pkg::DELAY_W)
  ) u_complete_timer (
    .clk(sys_clk),
    .rst_n(rst_n),
    .ce(clk_en),
    .tick(tick_reg),
    .raw_in(complete_raw),
    .on_delay(on_delay_reg),
    .off_delay(off_delay_reg),
    .delayed_out(complete_delayed)
  );

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      orient_complete_out <= 1'b0;
      orienting_out <= 1'b0;
    end
    else if (clk_en)
    begin
      orient_complete_out <= force_on || complete_delayed; // R3 R6 R7 R8
      orienting_out <= force_on || orienting_raw; // R2 R3
    end
  end

  // ********************
  // Monitors
  // ********************
  logic [oogs_pkg::POS_W-1:0] mon_stop_reg;
  logic [oogs_pkg::POS_W-1:0] mon_pos_reg;
  logic [15:0] mon_dev_reg;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mon_stop_reg <= '0;
      mon_pos_reg <= '0;
      mon_dev_reg <= '0;
    end
    else if (clk_en)
    begin
      mon_stop_reg <= stop_cmd; // R9
      mon_pos_reg <= shaft_position; // R10
      mon_dev_reg <= (dev_abs > oogs_pkg::DEV_LIMIT) ? 16'h0000 :
                     {dev[oogs_pkg::POS_W-1], dev}; // R11 R12
    end
  end

  // ********************
  // Gear set selection
  // ********************
  logic [oogs_pkg::SWT_W-1:0] switch_cnt_reg;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gear_set <= 2'h0;
      speed_reg_bank_b <= 1'b0;
    end
    else if (clk_en)
    begin
      gear_set <= {gear_select_hi, gear_select_lo}; // R13 R14
      speed_reg_bank_b <= gear_select_hi || gear_select_lo; // R14
    end
  end

  // Zero switch time disables the soft transition
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      switch_cnt_reg <= '0;
      reg_switch_active <= 1'b0;
    end
    else if (clk_en)
    begin
      if (speed_reg_bank_b != (gear_select_hi || gear_select_lo))
        switch_cnt_reg <= switch_time_reg; // R15
      else if (tick_reg && switch_cnt_reg != '0)
        switch_cnt_reg <= switch_cnt_reg - 1'b1;
      reg_switch_active <= (switch_cnt_reg != '0); // R15
    end
  end

  // ********************
  // AXI4-Lite write channel
  // ********************
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic do_write;
  logic [7:0] wr_ofs;
  logic [31:0] wr_merged;

  assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign wr_ofs = {aw_addr_reg[7:2], 2'h0};

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    return res;
  endfunction

  function automatic logic wr_known(input logic [7:0] ofs);
    return ofs == oogs_pkg::OFS_WIDTH_PRE || ofs == oogs_pkg::OFS_WIDTH_POST ||
           ofs == oogs_pkg::OFS_ON_DELAY || ofs == oogs_pkg::OFS_OFF_DELAY ||
           ofs == oogs_pkg::OFS_STOP_POS_INT || ofs == oogs_pkg::OFS_SWITCH_TIME;
  endfunction

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= oogs_pkg::RESP_OKAY;
    end
    else if (clk_en)
    begin
      s_axi_awready <= !aw_full_reg && !(s_axi_awready && s_axi_awvalid);
      s_axi_wready <= !w_full_reg && !(s_axi_wready && s_axi_wvalid);
      if (s_axi_awready && s_axi_awvalid)
      begin
        aw_addr_reg <= s_axi_awaddr;
        aw_full_reg <= 1'b1;
      end
      if (s_axi_wready && s_axi_wvalid)
      begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_full_reg <= 1'b1;
      end
      if (do_write)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known(wr_ofs) && (aw_addr_reg >> 8) == '0 ?
                       oogs_pkg::RESP_OKAY : oogs_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Only the word for the decoded offset is merged
  always_comb
  begin
    wr_merged = 32'h0;
    case (wr_ofs)
      oogs_pkg::OFS_WIDTH_PRE: wr_merged = {23'h0, width_pre_reg};
      oogs_pkg::OFS_WIDTH_POST: wr_merged = {23'h0, width_post_reg};
      oogs_pkg::OFS_ON_DELAY: wr_merged = {22'h0, on_delay_reg};
      oogs_pkg::OFS_OFF_DELAY: wr_merged = {22'h0, off_delay_reg};
      oogs_pkg::OFS_STOP_POS_INT: wr_merged = {17'h0, stop_pos_int_reg};
      oogs_pkg::OFS_SWITCH_TIME: wr_merged = {16'h0, switch_time_reg};
      default: wr_merged = 32'h0;
    endcase
    wr_merged = merge(wr_merged, w_data_reg, w_strb_reg);
  end

  function automatic logic [oogs_pkg::DELAY_W-1:0] clamp_delay(input logic [31:0] v);
    // Values past the top of the range saturate rather than wrap
    return (v[31:oogs_pkg::DELAY_W] != '0 || v[oogs_pkg::DELAY_W-1:0] > oogs_pkg::DELAY_MAX) ?
           oogs_pkg::DELAY_MAX : v[oogs_pkg::DELAY_W-1:0];
  endfunction

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      width_pre_reg <= oogs_pkg::RST_WIDTH_PRE;
      width_post_reg <= oogs_pkg::RST_WIDTH_POST;
      on_delay_reg <= oogs_pkg::RST_ON_DELAY;
      off_delay_reg <= oogs_pkg::RST_OFF_DELAY;
      stop_pos_int_reg <= oogs_pkg::RST_STOP_POS_INT;
      switch_time_reg <= oogs_pkg::RST_SWITCH_TIME;
    end
    else if (clk_en && do_write && (aw_addr_reg >> 8) == '0)
    begin
      case (wr_ofs)
        oogs_pkg::OFS_WIDTH_PRE: width_pre_reg <= wr_merged[8:0]; // R4
        oogs_pkg::OFS_WIDTH_POST: width_post_reg <= wr_merged[8:0]; // R5
        oogs_pkg::OFS_ON_DELAY: on_delay_reg <= clamp_delay(wr_merged); // R6
        oogs_pkg::OFS_OFF_DELAY: off_delay_reg <= clamp_delay(wr_merged); // R7
        oogs_pkg::OFS_STOP_POS_INT: stop_pos_int_reg <= wr_merged[14:0];
        oogs_pkg::OFS_SWITCH_TIME: switch_time_reg <= wr_merged[15:0];
        default: ;
      endcase
    end
  end

  // ********************
  // AXI4-Lite read channel
  // ********************
  logic [31:0] rd_word;
  logic rd_hit;
  logic [31:0] status_word;
  logic [7:0] rd_ofs;

  assign rd_ofs = {s_axi_araddr[7:2], 2'h0};

  always_comb
  begin
    status_word = 32'h0;
    status_word[oogs_pkg::ST_COMPLETE] = orient_complete_out;
    status_word[oogs_pkg::ST_ORIENTING] = orienting_out;
    status_word[oogs_pkg::ST_POST_WIDTH] = post_width_reg;
    status_word[oogs_pkg::ST_RAW_COMPLETE] = complete_raw;
    status_word[oogs_pkg::ST_GEAR_LSB +: 2] = gear_set;
    status_word[oogs_pkg::ST_BANK_B] = speed_reg_bank_b;
    status_word[oogs_pkg::ST_SWITCHING] = reg_switch_active;
    status_word[oogs_pkg::ST_FORCED] = force_on;
  end

  always_comb
  begin
    rd_hit = ((s_axi_araddr >> 8) == '0);
    rd_word = 32'h0;
    case (rd_ofs)
      oogs_pkg::OFS_WIDTH_PRE: rd_word = {23'h0, width_pre_reg};
      oogs_pkg::OFS_WIDTH_POST: rd_word = {23'h0, width_post_reg};
      oogs_pkg::OFS_ON_DELAY: rd_word = {22'h0, on_delay_reg};
      oogs_pkg::OFS_OFF_DELAY: rd_word = {22'h0, off_delay_reg};
      oogs_pkg::OFS_STOP_POS_INT: rd_word = {17'h0, stop_pos_int_reg};
      oogs_pkg::OFS_SWITCH_TIME: rd_word = {16'h0, switch_time_reg};
      oogs_pkg::OFS_STATUS: rd_word = status_word;
      oogs_pkg::OFS_MON_STOP_POS: rd_word = {17'h0, mon_stop_reg}; // R9
      oogs_pkg::OFS_MON_POSITION: rd_word = {17'h0, mon_pos_reg}; // R10
      oogs_pkg::OFS_MON_DEVIATION: rd_word = {{16{mon_dev_reg[15]}}, mon_dev_reg}; // R11
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= oogs_pkg::RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (s_axi_arready && s_axi_arvalid)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_hit ? rd_word : 32'h0;
        s_axi_rresp <= rd_hit ? oogs_pkg::RESP_OKAY : oogs_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
      else if (!s_axi_rvalid)
        s_axi_arready <= 1'b1;
    end
  end

endmodule

// File: oogs_asserts.sv
`timescale 1ns/1ps
// ********************************
// Port checker
// ********************************
module oogs_asserts (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic orientation_request,
  input wire logic run_cmd,
  input wire logic coast_stop_cmd,
  input wire logic alarm_active,
  input wire logic gear_select_lo,
  input wire logic gear_select_hi,
  input wire logic orient_complete_out,
  input wire logic orienting_out,
  input wire logic [1:0] gear_set,
  input wire logic speed_reg_bank_b,
  input wire logic reg_switch_active,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [1:0] up_reg;
  logic live;
  logic forced;
  // Outputs mean nothing until the reset synchroniser has drained
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      up_reg <= 2'h0;
    else if (up_reg != 2'h3)
      up_reg <= up_reg + 2'h1;
  end
  assign live = (up_reg == 2'h3) && clk_en;
  assign forced = !run_cmd || coast_stop_cmd || alarm_active;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  property p_force_orienting;
    live && forced |=> orienting_out;
  endproperty
  a_force_orienting: assert property (p_force_orienting)
    else $error("orienting output not forced on");
  property p_force_complete;
    live && forced |=> orient_complete_out;
  endproperty
  a_force_complete: assert property (p_force_complete)
    else $error("completion output not forced on");
  property p_idle_orienting;
    live && !forced && !orientation_request |=> !orienting_out;
  endproperty
  a_idle_orienting: assert property (p_idle_orienting)
    else $error("orienting output on without request");
  property p_gear;
    live |-> gear_set == {$past(gear_select_hi), $past(gear_select_lo)};
  endproperty
  a_gear: assert property (p_gear)
    else $error("gear set does not follow select inputs");
  property p_bank;
    live |-> speed_reg_bank_b == ($past(gear_select_hi) || $past(gear_select_lo));
  endproperty
  a_bank: assert property (p_bank)
    else $error("regulator bank decode wrong");
  property p_group;
    live && $changed(speed_reg_bank_b) |-> $changed(gear_set);
  endproperty
  a_group: assert property (p_group)
    else $error("bank switched apart from gear set");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read answer dropped before taken");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("read address taken while answer pending");
  c_complete: cover property (live && !forced && $rose(orient_complete_out));
  c_switch: cover property (reg_switch_active);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind oogs_orient_out oogs_asserts u_chk (.*);

// File: oogs_seq_model.sv
`timescale 1ns/1ps
// ********************************
// Machine sequencer terminals
// ********************************
module oogs_seq_model (
  input wire logic sys_clk,
  input wire logic [36:0] want,
  output logic orientation_request,
  output logic run_cmd,
  output logic coast_stop_cmd,
  output logic alarm_active,
  output logic shaft_at_rest,
  output logic gear_select_lo,
  output logic gear_select_hi,
  output logic [14:0] shaft_position,
  output logic [14:0] stop_pos_ext
);
  // Terminals start idle with run off, so the drive begins forced on
  logic [36:0] q_reg = 37'h0000000000;
  always @(posedge sys_clk)
    q_reg <= want;
  assign shaft_at_rest = q_reg[36];
  assign gear_select_hi = q_reg[35];
  assign gear_select_lo = q_reg[34];
  assign alarm_active = q_reg[33];
  assign coast_stop_cmd = q_reg[32];
  assign run_cmd = q_reg[31];
  assign orientation_request = q_reg[30];
  assign shaft_position = q_reg[29:15];
  assign stop_pos_ext = q_reg[14:0];
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module tb_top;
  typedef struct packed {
    logic [6:0] c;
    logic [14:0] p;
    logic [14:0] e;
    logic [1:0] oc;
    logic [31:0] dev;
    logic [14:0] stop;
  } oogs_row_s;
  localparam int TC = 10;
  localparam int NR = 11;
  // ********************************
  // Signals
  // ********************************
  int n_mismatch = 0, check_count = 0, n;
  logic [31:0] d;
  logic [1:0] r;
  logic sys_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1;
  logic [36:0] want = 37'h0000000000;
  logic orientation_request, run_cmd, coast_stop_cmd, alarm_active, shaft_at_rest;
  logic gear_select_lo, gear_select_hi, orient_complete_out, orienting_out;
  logic speed_reg_bank_b, reg_switch_active;
  logic [1:0] gear_set, s_axi_bresp, s_axi_rresp;
  logic [14:0] shaft_position, stop_pos_ext;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  // Row: terminals {rest,hi,lo,alarm,coast,run,req}, position, external stop,
  // {orienting,complete}, deviation monitor, stop monitor; internal stop is 0x14
  oogs_row_s rows [NR] = '{
    '{7'h03, 15'h078, 15'h064, 2'h1, 32'h0, 15'h078},
    '{7'h03, 15'h082, 15'h064, 2'h1, 32'ha, 15'h078},
    '{7'h03, 15'h083, 15'h064, 2'h2, 32'hb, 15'h078},
    '{7'h03, 15'h06d, 15'h064, 2'h2, 32'hfffffff5, 15'h078},
    '{7'h03, 15'h26d, 15'h064, 2'h2, 32'h0, 15'h078},
    '{7'h03, 15'h26c, 15'h064, 2'h2, 32'h1f4, 15'h078},
    '{7'h03, 15'h005, 15'h7ff8, 2'h1, 32'hfffffff9, 15'h00c},
    '{7'h02, 15'h078, 15'h064, 2'h0, 32'h0, 15'h078},
    '{7'h01, 15'h078, 15'h064, 2'h3, 32'h0, 15'h078},
    '{7'h07, 15'h078, 15'h064, 2'h3, 32'h0, 15'h078},
    '{7'h0b, 15'h078, 15'h064, 2'h3, 32'h0, 15'h078}};
  always #4 sys_clk = ~sys_clk;
  oogs_orient_out #(.TICK_CYCLES(TC)) dut (.*);
  oogs_seq_model seq (.*);
  // ********************************
  // Tasks
  // ********************************
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic drive(input logic [6:0] c, input logic [14:0] p, input logic [14:0] e);
    want <= {c, p, e};
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dw, output logic [1:0] rs);
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= dw;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (pa || pw)
    begin
      @(posedge sys_clk);
      if (pa && s_axi_awready)
      begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (pw && s_axi_wready)
      begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dr, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    // Late ready makes the slave hold its answer one cycle
    @(posedge sys_clk);
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    dr = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] dw);
    logic [1:0] rs;
    wr(a, dw, rs);
    `CHK(rs, oogs_pkg::RESP_OKAY)
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] dr;
    logic [1:0] rs;
    rd(a, dr, rs);
    `CHK(dr, e)
  endtask
  task automatic wait_c(input logic v, output int k);
    k = 0;
    while (orient_complete_out !== v && k < 100)
    begin
      @(posedge sys_clk);
      k++;
      if (k == 5)
        `CHK(orienting_out, !v)
    end
  endtask
  task automatic done(input string s);
    $display("test %0s finished", s);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ********************************
  // Sequence
  // ********************************
  initial
  begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    cyc(4);
    rc(oogs_pkg::OFS_WIDTH_PRE, 32'(oogs_pkg::RST_WIDTH_PRE));
    rc(oogs_pkg::OFS_WIDTH_POST, 32'(oogs_pkg::RST_WIDTH_POST));
    rc(oogs_pkg::OFS_ON_DELAY, 32'(oogs_pkg::RST_ON_DELAY));
    done("reset");
    w(oogs_pkg::OFS_STOP_POS_INT, 32'h14);
    for (int i = 0; i < NR; i++)
    begin
      drive(rows[i].c, rows[i].p, rows[i].e);
      cyc(8);
      `CHK({orienting_out, orient_complete_out}, rows[i].oc)
      rc(oogs_pkg::OFS_MON_DEVIATION, rows[i].dev);
      rc(oogs_pkg::OFS_MON_STOP_POS, {17'h0, rows[i].stop});
      rc(oogs_pkg::OFS_MON_POSITION, {17'h0, rows[i].p});
    end
    done("table");
    w(oogs_pkg::OFS_WIDTH_PRE, 32'h1ff);
    rc(oogs_pkg::OFS_WIDTH_PRE, 32'h1ff);
    drive(7'h03, 15'h277, 15'h064);
    cyc(8);
    `CHK(orient_complete_out, 1'b1)
    drive(7'h03, 15'h278, 15'h064);
    cyc(8);
    `CHK(orienting_out, 1'b1)
    w(oogs_pkg::OFS_WIDTH_PRE, 32'ha);
    drive(7'h43, 15'h080, 15'h064);
    cyc(10);
    `CHK(orienting_out, 1'b1)
    drive(7'h02, 15'h080, 15'h064);
    cyc(4);
    drive(7'h03, 15'h080, 15'h064);
    cyc(8);
    `CHK({orienting_out, orient_complete_out}, 2'h1)
    done("width");
    w(oogs_pkg::OFS_ON_DELAY, 32'h3ff);
    rc(oogs_pkg::OFS_ON_DELAY, 32'(oogs_pkg::DELAY_MAX));
    w(oogs_pkg::OFS_ON_DELAY, 32'h3);
    w(oogs_pkg::OFS_OFF_DELAY, 32'h2);
    drive(7'h03, 15'h083, 15'h064);
    cyc(40);
    drive(7'h03, 15'h078, 15'h064);
    wait_c(1'b1, n);
    `CHK((n >= 2 * TC) && (n <= 3 * TC + 5), 1'b1)
    drive(7'h03, 15'h083, 15'h064);
    wait_c(1'b0, n);
    `CHK((n >= TC) && (n <= 2 * TC + 5), 1'b1)
    w(oogs_pkg::OFS_ON_DELAY, 32'h0);
    w(oogs_pkg::OFS_OFF_DELAY, 32'h0);
    done("delay");
    w(oogs_pkg::OFS_SWITCH_TIME, 32'h3);
    for (int g = 0; g < 4; g++)
    begin
      drive({1'b0, 2'(g), 4'h3}, 15'h078, 15'h064);
      cyc(6);
      `CHK(gear_set, 2'(g))
      `CHK(speed_reg_bank_b, g != 0)
      if (g == 1)
        `CHK(reg_switch_active, 1'b1)
    end
    done("gear");
    rd(8'h30, d, r);
    `CHK({d, r}, {32'h0, oogs_pkg::RESP_SLVERR})
    wr(oogs_pkg::OFS_STATUS, 32'h1, r);
    `CHK(r, oogs_pkg::RESP_SLVERR)
    arst_n <= 1'b0;
    cyc(3);
    arst_n <= 1'b1;
    cyc(4);
    rc(oogs_pkg::OFS_STOP_POS_INT, 32'h0);
    done("bus");
    print_verdict();
  end
endmodule
